//--- core/qenc_ch_if.sv
// Configuration and results between the register file and one module
`timescale 1ns/1ps
`default_nettype none
interface qenc_ch_if;
  // Settings from the register file
  logic step_mode;
  logic round_mode;
  logic idx_inv;
  logic idx_arm;
  logic cnt_clr;
  logic [31:0] cpr;
  logic [31:0] recip;
  logic [31:0] min_per;
  logic [31:0] vel_num;
  // Results back
  logic [31:0] cnt;
  logic [31:0] raw;
  logic [31:0] pos;
  logic [31:0] vel;
  logic idx_evt;
  logic bad_evt;
  modport regs (output step_mode, round_mode, idx_inv, idx_arm, cnt_clr, cpr, recip,
    min_per, vel_num, input cnt, raw, pos, vel, idx_evt, bad_evt);
  modport chan (input step_mode, round_mode, idx_inv, idx_arm, cnt_clr, cpr, recip,
    min_per, vel_num, output cnt, raw, pos, vel, idx_evt, bad_evt);
endinterface
`default_nettype wire

//--- core/qenc_chan.sv
// One encoder module: input filter, decoder, counters, velocity timer
`timescale 1ns/1ps
`default_nettype none
module qenc_chan (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic a_i,
  input wire logic b_i,
  input wire logic z_i,
  qenc_ch_if.chan cf
);
  import qenc_pkg::*;
  // Whole module state
  typedef struct packed {
    logic [2:0] s1, s2, h0, h1, flt, wu;
    logic [31:0] cnt, raw, ph, pos, tmr, per, dvs, rem, num, vel;
    logic [5:0] bitc;
    qenc_div_e dst;
    logic dir, seen, ie, be;
  } qenc_ch_s;
  qenc_ch_s q, n;
  logic [2:0] stab, chg;
  logic step, up;
  logic [31:0] delta, ph1, eff;
  logic [32:0] r;
  logic qb;
  logic signed [64:0] prod;

  // Next state
  always_comb begin
    n = q;
    // Two flops then three equal samples before an edge counts
    n.s1 = {z_i, b_i, a_i};
    n.s2 = q.s1;
    n.h0 = q.s2;
    n.h1 = q.h0;
    stab = ~(q.s2 ^ q.h0) & ~(q.h0 ^ q.h1);
    n.flt = (q.flt & ~stab) | (q.h0 & stab);
    // Fill the filter from the pins after reset, so a pin resting high
    // is taken as a level and not as an edge
    n.wu = {q.wu[1:0], 1'b1};
    if (!q.wu[2]) begin
      n.flt = q.s2;
    end
    chg = q.wu[2] ? (n.flt ^ q.flt) : 3'b000;
    step = 1'b0;
    up = 1'b0;
    n.be = 1'b0;
    n.ie = 1'b0;
    if (cf.step_mode) begin
      // Rising A steps, B gives direction
      step = chg[0] & n.flt[0];
      up = n.flt[1];
    end else if (chg[1:0] == 2'b11) begin
      // Both changed at once: no count
      n.be = 1'b1;
    end else begin
      // Every edge of A or B counts, 4x
      step = |chg[1:0];
      up = n.flt[0] ^ q.flt[1];
    end
    delta = step ? (up ? 32'h0000_0001 : 32'hFFFF_FFFF) : 32'h0000_0000;
    // Raw count ignores reset and index
    n.raw = q.raw + delta;
    n.cnt = q.cnt + delta;
    // Phase within a revolution, kept for rounding
    ph1 = q.ph + 32'h0000_0001;
    if (step && up) begin
      n.ph = (ph1 >= cf.cpr) ? 32'h0000_0000 : ph1;
    end else if (step) begin
      n.ph = (q.ph == 32'h0000_0000 || q.ph >= cf.cpr) ? cf.cpr - 32'h0000_0001 :
        q.ph - 32'h0000_0001;
    end
    // Index edge, polarity selectable
    if (chg[2] && (n.flt[2] ^ cf.idx_inv) && cf.idx_arm) begin
      n.ie = 1'b1;
      if (cf.round_mode && cf.cpr != 32'h0000_0000) begin
        // Snap to the nearest revolution
        if (n.ph < {1'b0, cf.cpr[31:1]}) begin
          n.cnt = n.cnt - n.ph;
        end else begin
          n.cnt = n.cnt + (cf.cpr - n.ph);
        end
      end else begin
        n.cnt = 32'h0000_0000;
      end
      n.ph = 32'h0000_0000;
    end
    // Reset input holds count and position at zero
    if (cf.cnt_clr) begin
      n.cnt = 32'h0000_0000;
      n.ph = 32'h0000_0000;
    end
    // Position is count times reciprocal scale
    prod = $signed(n.cnt) * $signed({1'b0, cf.recip});
    n.pos = cf.cnt_clr ? 32'h0000_0000 : prod[FRAC+31:FRAC];
    // Interval timer between counts
    if (step) begin
      n.per = (q.tmr == 32'h0000_0000) ? 32'h0000_0001 : q.tmr;
      n.tmr = 32'h0000_0001;
      n.dir = up;
      n.seen = 1'b1;
    end else if (q.tmr != 32'hFFFF_FFFF) begin
      n.tmr = q.tmr + 32'h0000_0001;
    end
    // A stalled axis decays: use the longer of last period and elapsed time
    eff = (q.tmr > q.per) ? q.tmr : q.per;
    r = 33'h0_0000_0000;
    qb = 1'b0;
    case (q.dst)
      DV_IDLE: begin
        n.dvs = eff;
        n.num = cf.vel_num;
        n.rem = 32'h0000_0000;
        n.bitc = DIV_STEPS;
        n.dst = DV_RUN;
      end
      DV_RUN: begin
        // One restoring step per clock
        r = {q.rem, q.num[31]};
        if (r >= {1'b0, q.dvs}) begin
          r = r - {1'b0, q.dvs};
          qb = 1'b1;
        end
        n.rem = r[31:0];
        n.num = {q.num[30:0], qb};
        n.bitc = q.bitc - 6'h01;
        if (q.bitc == 6'h01) begin
          n.dst = DV_DONE;
        end
      end
      DV_DONE: begin
        // Long period means below minimum speed: report zero
        if (!q.seen || q.dvs > cf.min_per) begin
          n.vel = 32'h0000_0000;
        end else begin
          n.vel = q.dir ? q.num : 32'h0000_0000 - q.num;
        end
        n.dst = DV_IDLE;
      end
      default: begin
        n.dst = DV_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // Results
  assign cf.cnt = q.cnt;
  assign cf.raw = q.raw;
  assign cf.pos = q.pos;
  assign cf.vel = q.vel;
  assign cf.idx_evt = q.ie;
  assign cf.bad_evt = q.be;
endmodule
`default_nettype wire

//--- core/qenc_pkg.sv
// Shared constants and types of the six-axis encoder counter
package qenc_pkg;
  // Number of encoder modules
  localparam int NCH = 6;
  // Register byte address width in bits
  localparam int AW = 9;
  // Control word width and bit positions
  localparam int CTRL_W = 5;
  localparam int B_STEPDIR = 0;
  localparam int B_ROUND = 1;
  localparam int B_INV = 2;
  localparam int B_ARM = 3;
  localparam int B_CLR = 4;
  // Per-module register offsets, each module owns a 0x40 window
  localparam logic [5:0] OFF_CTRL = 6'h00;
  localparam logic [5:0] OFF_CPR = 6'h04;
  localparam logic [5:0] OFF_RECIP = 6'h08;
  localparam logic [5:0] OFF_MINP = 6'h0C;
  localparam logic [5:0] OFF_VNUM = 6'h10;
  localparam logic [5:0] OFF_COUNT = 6'h14;
  localparam logic [5:0] OFF_RAW = 6'h18;
  localparam logic [5:0] OFF_POS = 6'h1C;
  localparam logic [5:0] OFF_VEL = 6'h20;
  // Interrupt registers
  localparam logic [8:0] OFF_IRQ_STS = 9'h180;
  localparam logic [8:0] OFF_IRQ_MSK = 9'h184;
  localparam int IRQ_W = 2 * NCH;
  // Reset values
  localparam logic [CTRL_W-1:0] RST_CTRL = 5'h00;
  localparam logic [31:0] RST_CPR = 32'h0000_0000;
  localparam logic [31:0] RST_RECIP = 32'h0001_0000;
  localparam logic [31:0] RST_MINP = 32'hFFFF_FFFF;
  localparam logic [31:0] RST_VNUM = 32'h0000_0000;
  // Fraction bits of the reciprocal scale, dropped from the position result
  localparam int FRAC = 16;
  // Divider iterations
  localparam logic [5:0] DIV_STEPS = 6'h20;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Velocity divider phases, Gray from idle through run to done
  typedef enum logic [1:0] {
    DV_IDLE = 2'b00,
    DV_RUN = 2'b01,
    DV_DONE = 2'b11
  } qenc_div_e;
endpackage

//--- core/qenc_top.sv
// Six-axis encoder counter with its AXI4-Lite register file
// Functional notes
// - Six identical modules, inputs A, B, index.
// - Counting runs in hardware, independent of host.
// - Reset input forces count and position zero.
// - Signed 32-bit raw count ignores reset, index.
// - Position equals count divided by position scale.
// - Index event clears arm flag until rearmed.
// - Step mode: rising A counts, B sets direction.
// - Step mode off: A and B decoded as quadrature.
// - Quadrature counts every edge, four per line.
// - Armed round mode snaps to nearest revolution.
// - Armed reset mode zeroes count at index.
// - Counts per revolution matter only in round mode.
// - Index invert selects falling edge, else rising.
// - Velocity from timed interval between encoder pulses.
// - Velocity below minimum speed reads as zero.
`timescale 1ns/1ps
`default_nettype none
module qenc_top (
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  // Encoder pins, one bit per module
  input wire logic [qenc_pkg::NCH-1:0] ENC_A_I,
  input wire logic [qenc_pkg::NCH-1:0] ENC_B_I,
  input wire logic [qenc_pkg::NCH-1:0] ENC_IDX_I,
  // AXI4-Lite write address
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [qenc_pkg::AW-1:0] S_AXI_AWADDR_I,
  // Write data
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  // Write response
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  output logic [1:0] S_AXI_BRESP_O,
  // Read address
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  input wire logic [qenc_pkg::AW-1:0] S_AXI_ARADDR_I,
  // Read data
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  // Level interrupt
  output logic IRQ_O
);
  import qenc_pkg::*;

  // Whole register-file state
  typedef struct packed {
    logic [NCH-1:0][CTRL_W-1:0] ctrl;
    logic [NCH-1:0][31:0] cpr;
    logic [NCH-1:0][31:0] recip;
    logic [NCH-1:0][31:0] minp;
    logic [NCH-1:0][31:0] vnum;
    logic [IRQ_W-1:0] ists;
    logic [IRQ_W-1:0] imsk;
    logic aw_ok;
    logic w_ok;
    logic [AW-1:0] awa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic bv;
    logic [1:0] br;
    logic rv;
    logic [31:0] rd;
    logic [1:0] rr;
  } qenc_top_s;

  qenc_top_s q, n;

  // Results gathered from the modules
  logic [NCH-1:0][31:0] cnt_a;
  logic [NCH-1:0][31:0] raw_a;
  logic [NCH-1:0][31:0] pos_a;
  logic [NCH-1:0][31:0] vel_a;
  logic [NCH-1:0] idx_ev;
  logic [NCH-1:0] bad_ev;

  // Decode helpers
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] wclr;
  logic [31:0] wv;
  logic [2:0] wch;
  logic [5:0] woff;
  logic [2:0] rch;
  logic [5:0] roff;

  // One module per axis
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    qenc_ch_if cif ();
    // Settings out of the register file
    assign cif.step_mode = q.ctrl[g][B_STEPDIR];
    assign cif.round_mode = q.ctrl[g][B_ROUND];
    assign cif.idx_inv = q.ctrl[g][B_INV];
    assign cif.idx_arm = q.ctrl[g][B_ARM];
    assign cif.cnt_clr = q.ctrl[g][B_CLR];
    assign cif.cpr = q.cpr[g];
    assign cif.recip = q.recip[g];
    assign cif.min_per = q.minp[g];
    assign cif.vel_num = q.vnum[g];
    // Results back in
    assign cnt_a[g] = cif.cnt;
    assign raw_a[g] = cif.raw;
    assign pos_a[g] = cif.pos;
    assign vel_a[g] = cif.vel;
    assign idx_ev[g] = cif.idx_evt;
    assign bad_ev[g] = cif.bad_evt;
    qenc_chan u_chan (
      .clk_i(CORE_CLK_I),
      .rst_i(RST_I),
      .a_i(ENC_A_I[g]),
      .b_i(ENC_B_I[g]),
      .z_i(ENC_IDX_I[g]),
      .cf(cif)
    );
  end

  // Byte-lane merge of a write
  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
      input logic [3:0] s);
    logic [31:0] m;
    m = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        m[8*b +: 8] = d[8*b +: 8];
      end
    end
    return m;
  endfunction

  // Handshake outputs
  assign S_AXI_AWREADY_O = !q.aw_ok && !q.bv;
  assign S_AXI_WREADY_O = !q.w_ok && !q.bv;
  assign S_AXI_ARREADY_O = !q.rv;
  assign S_AXI_BVALID_O = q.bv;
  assign S_AXI_BRESP_O = q.br;
  assign S_AXI_RVALID_O = q.rv;
  assign S_AXI_RDATA_O = q.rd;
  assign S_AXI_RRESP_O = q.rr;

  // Interrupt while any unmasked sticky bit is set
  assign IRQ_O = |(q.ists & q.imsk);

  // Next state of the register file and bus slave
  always_comb begin
    n = q;
    wclr = '0;
    wv = 32'h0000_0000;
    wch = q.awa[8:6];
    woff = q.awa[5:0];
    rch = S_AXI_ARADDR_I[8:6];
    roff = S_AXI_ARADDR_I[5:0];
    ev = {bad_ev, idx_ev};
    // Address and data are taken in either order
    if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
      n.aw_ok = 1'b1;
      n.awa = S_AXI_AWADDR_I;
    end
    if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
      n.w_ok = 1'b1;
      n.wd = S_AXI_WDATA_I;
      n.ws = S_AXI_WSTRB_I;
    end
    // Responses retire on their ready
    if (q.bv && S_AXI_BREADY_I) begin
      n.bv = 1'b0;
    end
    if (q.rv && S_AXI_RREADY_I) begin
      n.rv = 1'b0;
    end
    // An index event disarms its module
    for (int k = 0; k < NCH; k++) begin
      if (idx_ev[k]) begin
        n.ctrl[k][B_ARM] = 1'b0;
      end
    end
    // Commit a write once both halves are held
    if (q.aw_ok && q.w_ok && !q.bv) begin
      n.aw_ok = 1'b0;
      n.w_ok = 1'b0;
      n.bv = 1'b1;
      n.br = RESP_OKAY;
      if (wch < 3'(NCH)) begin
        case (woff)
          OFF_CTRL: begin
            // A same-cycle rearm by software beats the disarm
            // Merge onto the disarmed value, so an unstrobed byte keeps it
            wv = wmerge({27'h000_0000, n.ctrl[wch]}, q.wd, q.ws);
            n.ctrl[wch] = wv[CTRL_W-1:0];
          end
          OFF_CPR: begin
            n.cpr[wch] = wmerge(q.cpr[wch], q.wd, q.ws);
          end
          OFF_RECIP: begin
            n.recip[wch] = wmerge(q.recip[wch], q.wd, q.ws);
          end
          OFF_MINP: begin
            n.minp[wch] = wmerge(q.minp[wch], q.wd, q.ws);
          end
          OFF_VNUM: begin
            n.vnum[wch] = wmerge(q.vnum[wch], q.wd, q.ws);
          end
          OFF_COUNT, OFF_RAW, OFF_POS, OFF_VEL: begin
            // Read-only results, write ignored
            n.br = RESP_OKAY;
          end
          default: begin
            n.br = RESP_SLVERR;
          end
        endcase
      end else if (q.awa == OFF_IRQ_STS) begin
        // Write one to clear
        wv = wmerge(32'h0000_0000, q.wd, q.ws);
        wclr = wv[IRQ_W-1:0];
      end else if (q.awa == OFF_IRQ_MSK) begin
        wv = wmerge({20'h0_0000, q.imsk}, q.wd, q.ws);
        n.imsk = wv[IRQ_W-1:0];
      end else begin
        n.br = RESP_SLVERR;
      end
    end
    // Sticky events; a new event beats a same-cycle clear
    n.ists = (q.ists & ~wclr) | ev;
    // Read: answer in the cycle after the address is taken
    if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
      n.rv = 1'b1;
      n.rr = RESP_OKAY;
      n.rd = 32'h0000_0000;
      if (rch < 3'(NCH)) begin
        case (roff)
          OFF_CTRL: begin
            n.rd = {27'h000_0000, q.ctrl[rch]};
          end
          OFF_CPR: begin
            n.rd = q.cpr[rch];
          end
          OFF_RECIP: begin
            n.rd = q.recip[rch];
          end
          OFF_MINP: begin
            n.rd = q.minp[rch];
          end
          OFF_VNUM: begin
            n.rd = q.vnum[rch];
          end
          OFF_COUNT: begin
            n.rd = cnt_a[rch];
          end
          OFF_RAW: begin
            n.rd = raw_a[rch];
          end
          OFF_POS: begin
            n.rd = pos_a[rch];
          end
          OFF_VEL: begin
            n.rd = vel_a[rch];
          end
          default: begin
            n.rr = RESP_SLVERR;
          end
        endcase
      end else if (S_AXI_ARADDR_I == OFF_IRQ_STS) begin
        n.rd = {20'h0_0000, q.ists};
      end else if (S_AXI_ARADDR_I == OFF_IRQ_MSK) begin
        n.rd = {20'h0_0000, q.imsk};
      end else begin
        n.rr = RESP_SLVERR;
      end
    end
  end

  // State register with constant reset values
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      q <= '0;
      q.ctrl <= {NCH{RST_CTRL}};
      q.cpr <= {NCH{RST_CPR}};
      q.recip <= {NCH{RST_RECIP}};
      q.minp <= {NCH{RST_MINP}};
      q.vnum <= {NCH{RST_VNUM}};
    end else begin
      q <= n;
    end
  end
endmodule
`default_nettype wire

//--- verification/qenc_enc_model.sv
// Behavioural encoder and step/direction source for all six axes
`timescale 1ns/1ps
`default_nettype none
module qenc_enc_model (
  input wire logic clk_i,
  output logic [qenc_pkg::NCH-1:0] a_o,
  output logic [qenc_pkg::NCH-1:0] b_o,
  output logic [qenc_pkg::NCH-1:0] z_o
);
  import qenc_pkg::*;
  // Cycles each level stands; the input filter needs three
  int hold_cyc = 8;
  // Lines idle low until the first move
  initial begin
    a_o = '0;
    b_o = '0;
    z_o = '0;
  end
  // Let one level stand
  task automatic dwell();
    repeat (hold_cyc) @(posedge clk_i);
  endtask
  // n steps: A pulse with B as direction, or one quadrature edge each
  task automatic run(input int k, input bit st, input int n, input bit up);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      if (st) begin
        b_o[k] <= up;
        dwell();
        a_o[k] <= 1'b1;
        dwell();
        a_o[k] <= 1'b0;
      end else if (up == (a_o[k] == b_o[k])) begin
        a_o[k] <= ~a_o[k];
      end else begin
        b_o[k] <= ~b_o[k];
      end
      dwell();
    end
  endtask
  // One index edge per call, long enough to settle the count
  task automatic idx(input int k);
    @(posedge clk_i);
    z_o[k] <= ~z_o[k];
    dwell();
    dwell();
  endtask
  // Both channels flipped together, a broken quadrature step
  task automatic bad(input int k);
    @(posedge clk_i);
    a_o[k] <= ~a_o[k];
    b_o[k] <= ~b_o[k];
    dwell();
  endtask
endmodule
`default_nettype wire

//--- verification/qenc_top_props.sv
// Bus and interrupt checks of the encoder counter, bound to its top
`timescale 1ns/1ps
`default_nettype none
module qenc_top_props (
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic S_AXI_AWVALID_I,
  input wire logic S_AXI_AWREADY_O,
  input wire logic S_AXI_WVALID_I,
  input wire logic S_AXI_WREADY_O,
  input wire logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [1:0] S_AXI_BRESP_O,
  input wire logic S_AXI_ARVALID_I,
  input wire logic S_AXI_ARREADY_O,
  input wire logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire logic [31:0] S_AXI_RDATA_O,
  input wire logic [1:0] S_AXI_RRESP_O,
  input wire logic IRQ_O
);
  import qenc_pkg::*;
  // One clock domain, reset silences everything
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);
  a_bresp_holds: assert property (
    S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
    else $error("write response changed before taken");
  a_rdata_holds: assert property (
    S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
    else $error("read data changed before taken");
  a_read_answer: assert property (
    S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
    else $error("read not answered one cycle after address");
  a_write_answer: assert property (
    S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O
    |-> ##[1:2] S_AXI_BVALID_O) else $error("write not answered in time");
  a_ar_blocked: assert property (
    S_AXI_RVALID_O |-> !S_AXI_ARREADY_O) else $error("read address taken while busy");
  a_aw_blocked: assert property (
    S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O)
    else $error("write taken while response pending");
  a_err_zero: assert property (
    S_AXI_RVALID_O && S_AXI_RRESP_O == RESP_SLVERR |-> S_AXI_RDATA_O == 32'h0)
    else $error("error read returned data");
  a_bvalid_clears: assert property (
    S_AXI_BVALID_O && S_AXI_BREADY_I |=> !S_AXI_BVALID_O)
    else $error("write response repeated");
  a_rvalid_clears: assert property (
    S_AXI_RVALID_O && S_AXI_RREADY_I |=> !S_AXI_RVALID_O)
    else $error("read response repeated");
  a_irq_after_rst: assert property (
    $fell(RST_I) |-> !IRQ_O) else $error("interrupt high just after reset");
endmodule
bind qenc_top qenc_top_props i_qenc_top_props (.CORE_CLK_I, .RST_I, .S_AXI_AWVALID_I,
  .S_AXI_AWREADY_O, .S_AXI_WVALID_I, .S_AXI_WREADY_O, .S_AXI_BVALID_O, .S_AXI_BREADY_I,
  .S_AXI_BRESP_O, .S_AXI_ARVALID_I, .S_AXI_ARREADY_O, .S_AXI_RVALID_O, .S_AXI_RREADY_I,
  .S_AXI_RDATA_O, .S_AXI_RRESP_O, .IRQ_O);
`default_nettype wire

//--- verification/qenc_top_tb.sv
// Self-checking bench of the six-axis encoder counter
`timescale 1ns/1ps
`default_nettype none
module qenc_top_tb;
  import qenc_pkg::*;
  // Ordinary case: module, control word, steps, direction, count
  typedef struct {int k; logic [31:0] ctrl; int n; bit up; logic [31:0] cnt;} qenc_row_s;
  logic clk, rst, awv, wv, br, arv, rr, irq, awr, wr, bv, arr, rv;
  logic [AW-1:0] awa, ara;
  logic [31:0] wd, rdat, got;
  // Strobes driven to the bus, and the ones the next write uses
  logic [3:0] ws;
  logic [3:0] wmask = 4'hF;
  logic [1:0] bresp, rresp, rsp;
  logic [NCH-1:0] ea, eb, ez;
  int n_mismatch = 0;
  int comparisons = 0;
  qenc_row_s rows [6] = '{'{0, 32'h0, 4, 1, 32'h4}, '{1, 32'h0, 6, 0, 32'hFFFF_FFFA},
    '{2, 32'h1, 3, 1, 32'h3}, '{3, 32'h1, 2, 0, 32'hFFFF_FFFE},
    '{4, 32'h0, 1, 1, 32'h1}, '{5, 32'h1, 5, 1, 32'h5}};
  // Design under test, every bus input driven by the tasks
  qenc_top i_qenc_top (.CORE_CLK_I(clk), .RST_I(rst), .ENC_A_I(ea), .ENC_B_I(eb),
    .ENC_IDX_I(ez), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_AWADDR_I(awa),
    .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(ws),
    .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(br), .S_AXI_BRESP_O(bresp),
    .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr), .S_AXI_ARADDR_I(ara),
    .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rr), .S_AXI_RDATA_O(rdat),
    .S_AXI_RRESP_O(rresp), .IRQ_O(irq));
  qenc_enc_model i_qenc_enc_model (.clk_i(clk), .a_o(ea), .b_o(eb), .z_o(ez));
  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Byte address of a module register
  function automatic logic [AW-1:0] ra(input int k, input logic [5:0] off);
    return AW'(k * 64) + AW'(off);
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Outputs sampled at the falling edge, inputs moved after the rising one
  task automatic wr_reg(input logic [AW-1:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tk;
    int t;
    @(posedge clk);
    awv <= 1'b1; wv <= 1'b1; awa <= a; wd <= d; br <= 1'b1;
    ws <= wmask;
    for (t = 0; t < 100; t++) begin
      @(negedge clk);
      ta = awv && awr; tw = wv && wr; tk = bv; rsp = bresp;
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      if (tk) break;
    end
    br <= 1'b0;
    if (t == 100) n_mismatch++;
    chk({30'h0, rsp}, {30'h0, er});
  endtask
  task automatic rd_reg(input logic [AW-1:0] a, output logic [31:0] d);
    logic ta, tv;
    int t;
    @(posedge clk);
    arv <= 1'b1; ara <= a; rr <= 1'b1;
    for (t = 0; t < 100; t++) begin
      @(negedge clk);
      ta = arv && arr; tv = rv; d = rdat; rsp = rresp;
      @(posedge clk);
      if (ta) arv <= 1'b0;
      if (tv) break;
    end
    rr <= 1'b0;
    if (t == 100) n_mismatch++;
  endtask
  task automatic rchk(input logic [AW-1:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd_reg(a, v);
    chk(v, e);
  endtask
  task automatic chk_irq(input logic e);
    @(negedge clk);
    chk({31'h0, irq}, {31'h0, e});
  endtask
  // Motion then settle time for the filter
  task automatic move(input int k, input bit st, input int n, input bit up);
    i_qenc_enc_model.run(k, st, n, up);
    repeat (10) @(posedge clk);
  endtask
  task automatic wrap_up();
    $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Hang guard, far beyond the roughly 1300 cycles the tests need
  initial begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    wrap_up();
  end
  initial begin
    rst = 1'b1; awv = 1'b0; wv = 1'b0; br = 1'b0; arv = 1'b0; rr = 1'b0;
    awa = '0; ara = '0; wd = '0;
    ws = 4'hF;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rchk(ra(0, OFF_CTRL), 32'h0);
    rchk(ra(1, OFF_RECIP), RST_RECIP);
    rchk(ra(2, OFF_MINP), RST_MINP);
    rchk(ra(3, OFF_CPR), RST_CPR);
    rchk(OFF_IRQ_STS, 32'h0);
    repeat (10) @(posedge clk);
    $display("reset values done");
    // Every module, both counting modes, both directions
    foreach (rows[i]) begin
      wr_reg(ra(rows[i].k, OFF_CTRL), rows[i].ctrl, RESP_OKAY);
      move(rows[i].k, rows[i].ctrl[0], rows[i].n, rows[i].up);
      rchk(ra(rows[i].k, OFF_COUNT), rows[i].cnt);
      rchk(ra(rows[i].k, OFF_RAW), rows[i].cnt);
    end
    $display("counting rows done");
    // Clear held: count and position zero, raw keeps going
    wr_reg(ra(0, OFF_CTRL), 32'h10, RESP_OKAY);
    move(0, 0, 2, 1);
    rchk(ra(0, OFF_COUNT), 32'h0);
    rchk(ra(0, OFF_POS), 32'h0);
    rchk(ra(0, OFF_RAW), 32'h6);
    wr_reg(ra(0, OFF_CTRL), 32'h0, RESP_OKAY);
    $display("clear test done");
    // Position is count times the reciprocal scale over 2^16: scale 1, then 2
    rchk(ra(1, OFF_POS), 32'hFFFF_FFFA);
    wr_reg(ra(1, OFF_RECIP), 32'h8000, RESP_OKAY);
    move(1, 0, 2, 0);
    rchk(ra(1, OFF_POS), 32'hFFFF_FFFC);
    $display("position test done");
    // Index reset, disarm, unarmed index, inverted edge
    wr_reg(OFF_IRQ_MSK, 32'h4, RESP_OKAY);
    wr_reg(ra(2, OFF_CTRL), 32'h9, RESP_OKAY);
    i_qenc_enc_model.idx(2);
    rchk(ra(2, OFF_COUNT), 32'h0);
    rchk(ra(2, OFF_CTRL), 32'h1);
    rchk(OFF_IRQ_STS, 32'h4);
    chk_irq(1'b1);
    i_qenc_enc_model.idx(2);
    move(2, 1, 2, 1);
    i_qenc_enc_model.idx(2);
    i_qenc_enc_model.idx(2);
    rchk(ra(2, OFF_COUNT), 32'h2);
    wr_reg(OFF_IRQ_STS, 32'h4, RESP_OKAY);
    chk_irq(1'b0);
    wr_reg(ra(2, OFF_CTRL), 32'hD, RESP_OKAY);
    i_qenc_enc_model.idx(2);
    rchk(ra(2, OFF_COUNT), 32'h2);
    i_qenc_enc_model.idx(2);
    rchk(ra(2, OFF_COUNT), 32'h0);
    $display("index test done");
    // Round to nearest revolution of 8 counts: 5 goes to 8
    wr_reg(ra(3, OFF_CPR), 32'h8, RESP_OKAY);
    wr_reg(ra(3, OFF_CTRL), 32'h11, RESP_OKAY);
    wr_reg(ra(3, OFF_CTRL), 32'h1, RESP_OKAY);
    move(3, 1, 5, 1);
    wr_reg(ra(3, OFF_CTRL), 32'hB, RESP_OKAY);
    i_qenc_enc_model.idx(3);
    rchk(ra(3, OFF_COUNT), 32'h8);
    rchk(ra(3, OFF_RAW), 32'h3);
    $display("round test done");
    // Broken step: no count, masked status bit, no interrupt
    i_qenc_enc_model.bad(4);
    repeat (10) @(posedge clk);
    rchk(ra(4, OFF_COUNT), 32'h1);
    // Index events of modules 2 and 3 are still pending beside the bad step
    rchk(OFF_IRQ_STS, 32'h0000_040C);
    wr_reg(OFF_IRQ_STS, 32'h4, RESP_OKAY);
    chk_irq(1'b0);
    $display("illegal step test done");
    // Velocity from pulse timing, then cut to zero by the speed floor
    wr_reg(ra(5, OFF_VNUM), 32'h0100_0000, RESP_OKAY);
    move(5, 1, 3, 1);
    // Let the divider take a period from after the last pulses
    repeat (40) @(posedge clk);
    rd_reg(ra(5, OFF_VEL), got);
    chk({31'h0, got > 32'h0001_B4E8 && got < 32'h000C_CCCD}, 32'h1);
    wr_reg(ra(5, OFF_MINP), 32'h14, RESP_OKAY);
    move(5, 1, 3, 1);
    repeat (40) @(posedge clk);
    rchk(ra(5, OFF_VEL), 32'h0);
    $display("velocity test done");
    // Unmapped and read-only places
    rd_reg(9'h1C0, got);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    chk(got, 32'h0);
    wr_reg(9'h1F0, 32'hFFFF_FFFF, RESP_SLVERR);
    wr_reg(ra(4, OFF_COUNT), 32'h55, RESP_OKAY);
    rchk(ra(4, OFF_COUNT), 32'h1);
    // Only the low byte lane strobed
    wmask = 4'h1;
    wr_reg(ra(4, OFF_CPR), 32'hFFFF_FFFF, RESP_OKAY);
    wmask = 4'hF;
    rchk(ra(4, OFF_CPR), 32'h0000_00FF);
    $display("bus test done");
    // Reset in mid-run: interrupt, settings and counts back to reset values
    wr_reg(OFF_IRQ_MSK, 32'h0000_0FFF, RESP_OKAY);
    chk_irq(1'b1);
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    chk_irq(1'b0);
    rchk(ra(2, OFF_CTRL), 32'h0);
    // Module 4 pins rest at B high: no false edge after reset
    rchk(ra(4, OFF_COUNT), 32'h0);
    rchk(ra(4, OFF_RAW), 32'h0);
    rchk(OFF_IRQ_STS, 32'h0);
    $display("mid-run reset test done");
    wrap_up();
  end
endmodule
`default_nettype wire
